// >>> rtl/pgpg_pkg.sv
// Purpose: Shared constants for the power-good and phase-gating supervisor
// Assumes: 100 MHz system clock, register commands arrive as decoded bytes
// Notes: Timing figures are kept in their own unit and converted to cycles

package pgpg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;                     // System clock rate
  localparam int BLANK_US = 100;                    // Voltage-code blanking time
  localparam int BLANK_CYCLES = BLANK_US * CLK_MHZ; // Blanking in cycles
  localparam int OFF_CODE_US = 5;                   // Off-code persistence time
  localparam int OFF_CODE_CYCLES = OFF_CODE_US * CLK_MHZ;
  localparam int MASK_US = 1000;                    // Turn-on delay default
  localparam int MASK_CYCLES = MASK_US * CLK_MHZ;
  localparam int CNT_W = 17;                        // Width of long counters

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_MANUFACTURER_CONFIG = 8'hD1;    // Low-power phase count
  localparam logic [7:0] CMD_HIGH_LIMIT = 8'hE0;    // Upper window limit
  localparam logic [7:0] CMD_LOW_LIMIT = 8'hE1;     // Lower window limit
  localparam logic [7:0] CMD_EN_VOLTAGE = 8'hD9;    // Enable-pin reading

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int PSI_PH_LSB = 6;                    // Phase count bits 7:6
  localparam int HI_LSB = 0;                        // High limit bits 1:0
  localparam int LO_LSB = 0;                        // Low limit bits 2:0
  localparam logic [7:0] MANUFACTURER_CONFIG_RST = 8'h00;    // One phase in low power
  localparam logic [7:0] HIGH_LIMIT_RST = 8'h00;    // +300 mV
  localparam logic [7:0] LOW_LIMIT_RST = 8'h00;     // -500 mV
  localparam logic [1:0] PSI_TWO_PHASE = 2'h1;      // Only code for two phases
  localparam logic [7:0] VID_OFF_LO = 8'h00;        // Off / no-processor codes
  localparam logic [7:0] VID_OFF_HI = 8'hFF;
  localparam int ADC_W = 10;                        // Enable-pin reading width

endpackage

// >>> rtl/pgpg_reg_if.sv
// Purpose: Carrier between the supervisor top and its register store
// Assumes: Single clock domain
// Notes: Write strobe is one cycle, read data is registered in the store

`timescale 1ns/1ps
`default_nettype none

interface pgpg_reg_if;
  logic wr;               // Write strobe
  logic [7:0] cmd;        // Command code
  logic [7:0] wdata;      // Write byte
  logic adc_valid;        // New enable-pin sample
  logic [9:0] adc_data;   // Enable-pin sample
  logic [7:0] manufacturer_config; // Stored configuration
  logic [7:0] high_limit; // Stored upper limit
  logic [7:0] low_limit;  // Stored lower limit
  logic [15:0] rdata;     // Registered read data

  modport top (
    output wr, cmd, wdata, adc_valid, adc_data,
    input manufacturer_config, high_limit, low_limit, rdata
  );
  modport store (
    input wr, cmd, wdata, adc_valid, adc_data,
    output manufacturer_config, high_limit, low_limit, rdata
  );
endinterface

`default_nettype wire

// >>> rtl/pgpg_regs.sv
// Purpose: Register store for limits, phase count and enable-pin reading
// Assumes: Commands decoded upstream by the bus engine
// Notes: Unmapped commands read zero and ignore writes

`timescale 1ns/1ps
`default_nettype none

module pgpg_regs
  import pgpg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register carrier
  pgpg_reg_if.store bus
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] manufacturer_config;  // Low-power phase selection
    logic [7:0] high_limit;  // Upper window code
    logic [7:0] low_limit;   // Lower window code
    logic [9:0] en_volt;     // Last enable-pin reading
    logic [15:0] rdata;      // Read data register
  } pgpg_regs_s;

  pgpg_regs_s r;
  pgpg_regs_s next_r;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Writes and read-back selection
  always_comb begin
    next_r = r;
    if (bus.wr) begin
      unique case (bus.cmd)
        CMD_MANUFACTURER_CONFIG: next_r.manufacturer_config = bus.wdata;
        CMD_HIGH_LIMIT: next_r.high_limit = bus.wdata;
        CMD_LOW_LIMIT: next_r.low_limit = bus.wdata;
        default: next_r.manufacturer_config = r.manufacturer_config;      // Unmapped write dropped
      endcase
    end
    // Converter result latched as it arrives
    if (bus.adc_valid) begin
      next_r.en_volt = bus.adc_data;
    end
    // Read data follows the command every cycle
    unique case (bus.cmd)
      CMD_MANUFACTURER_CONFIG: next_r.rdata = {8'h00, r.manufacturer_config};
      CMD_HIGH_LIMIT: next_r.rdata = {8'h00, r.high_limit};
      CMD_LOW_LIMIT: next_r.rdata = {8'h00, r.low_limit};
      CMD_EN_VOLTAGE: next_r.rdata = {6'h00, r.en_volt};
      default: next_r.rdata = 16'h0000;
    endcase
  end

  // Register update
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r <= '{MANUFACTURER_CONFIG_RST, HIGH_LIMIT_RST, LOW_LIMIT_RST, 10'h000, 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  assign bus.manufacturer_config = r.manufacturer_config;
  assign bus.high_limit = r.high_limit;
  assign bus.low_limit = r.low_limit;
  assign bus.rdata = r.rdata;

endmodule

`default_nettype wire

// >>> rtl/pgpg_top.sv
// Purpose: Power-good window, blanking, crowbar and low-power phase gating
// Assumes: Comparators, ramp and converter are analog blocks outside
// Notes: Pin inputs pass two flip-flops before use
//
// Function
// - Power-good low: out of window, off code, disabled
// - Voltage-code change blanks power-good for 100 us
// - Power-good held until ramp done and mask expired
// - Window limits reset to +300/-500 mV, writable
// - High-limit code selects +300 to +150 mV
// - Low-limit code selects -500 to -150 mV
// - Low-power input low drives gated disable low
// - Config bits 7:6 select low-power phase count
// - Four phases, two kept: phases 1 and 3
// - Crowbar forces PWM low until release level
// - Crowbar threshold follows the high-limit code
// - Start only with lockout clear and enable high
// - Disabled: PWM, power-good, both disables low
// - Enable-pin reading reported as 10-bit register
// - Each code change restarts blanking timer
// - Off code must persist 5 us before shutdown

`timescale 1ns/1ps
`default_nettype none

module pgpg_top
  import pgpg_pkg::*;
#(
  parameter int BLANK_CYC = BLANK_CYCLES,  // Shorten for simulation
  parameter int MASK_CYC = MASK_CYCLES     // Turn-on delay in cycles
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register command port from the bus engine
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_cmd,
  input wire logic [7:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // Pins and comparator results
  input wire logic [7:0] i_voltage_id_code,
  input wire logic i_enable,
  input wire logic i_undervoltage_lockout_clear,
  input wire logic i_low_power_state_in_n,
  input wire logic i_window_above,
  input wire logic i_window_below,
  input wire logic i_crowbar_trip,
  input wire logic i_crowbar_release,
  input wire logic i_soft_start_done,
  input wire logic [2:0] i_normal_phases,
  // Enable-pin converter, same clock
  input wire logic i_en_adc_valid,
  input wire logic [9:0] i_en_adc_data,
  // Outputs
  output logic o_power_ok_out_o,
  output logic o_power_ok_out_oe_n,
  output logic o_gated_phase_disable_n,
  output logic o_always_on_phase_disable_n,
  output logic o_pwm_force_low,
  output logic [3:0] o_phase_enable,
  output logic [1:0] o_high_limit_sel,
  output logic [2:0] o_low_limit_sel,
  output logic o_shutdown
);

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  pgpg_reg_if rif ();

  assign rif.wr = i_reg_wr;
  assign rif.cmd = i_reg_cmd;
  assign rif.wdata = i_reg_wdata;
  assign rif.adc_valid = i_en_adc_valid;
  assign rif.adc_data = i_en_adc_data;

  pgpg_regs u_regs (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bus(rif.store)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [18:0] meta;         // First synchroniser stage
    logic [18:0] sync;         // Second synchroniser stage
    logic [7:0] vid_prev;      // Last stable voltage code
    logic [CNT_W-1:0] blank;   // Blanking countdown
    logic [CNT_W-1:0] off_cnt; // Off-code persistence count
    logic [CNT_W-1:0] mask;    // Turn-on delay countdown
    logic ss_reached;          // Ramp has hit its target
    logic shutdown;            // Off code confirmed
    logic crowbar;             // Crowbar active
    logic pgood;               // Power good level
    logic gated_n;             // Gated phase disable
    logic always_n;            // Always-on phase disable
    logic pwm_low;             // Force PWM low
    logic [3:0] phase_en;      // Active phases
  } pgpg_top_s;

  pgpg_top_s s;
  pgpg_top_s next_s;

  // Synchronised views, read from the second stage only
  logic [7:0] voltage_id_code;
  logic en_s, undervoltage_lockout_clr_s, psi_n_s, above_s, below_s, trip_s, rel_s, ss_s;
  logic [2:0] nph_s;
  assign {nph_s, voltage_id_code, en_s, undervoltage_lockout_clr_s, psi_n_s, above_s, below_s, trip_s, rel_s, ss_s} =
    s.sync;

  // ----------------------------------------------------------------
  // Phase selection helper
  // ----------------------------------------------------------------
  // Phases kept in low power; three-phase two-keep uses 1 and 2
  function automatic logic [3:0] pgpg_psi_phases(input logic [1:0] sel,
                                                 input logic [2:0] nph);
    logic [3:0] m;
    m = 4'h1;
    if (sel == PSI_TWO_PHASE) begin
      m = (nph == 3'h4) ? 4'h5 : 4'h3;
    end
    return m;
  endfunction

  // Normal-operation phase mask from phase count
  function automatic logic [3:0] pgpg_all_phases(input logic [2:0] nph);
    logic [3:0] m;
    m = 4'hF;
    if (nph == 3'h2) begin
      m = 4'h3;
    end else if (nph == 3'h3) begin
      m = 4'h7;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Supervisor behaviour
  always_comb begin
    logic enabled;
    logic vid_off;
    logic in_window;
    // Decoded conditions first, so no local is read before it is set
    vid_off = (voltage_id_code == VID_OFF_LO) || (voltage_id_code == VID_OFF_HI);
    in_window = !above_s && !below_s;
    enabled = en_s && undervoltage_lockout_clr_s && !s.shutdown;
    next_s = s;
    // Two-stage capture of every pin input
    next_s.meta = {i_normal_phases, i_voltage_id_code, i_enable,
                   i_undervoltage_lockout_clear, i_low_power_state_in_n,
                   i_window_above, i_window_below, i_crowbar_trip,
                   i_crowbar_release, i_soft_start_done};
    next_s.sync = s.meta;

    // Blanking restarts on every code change
    next_s.vid_prev = voltage_id_code;
    if (voltage_id_code != s.vid_prev) begin
      next_s.blank = CNT_W'(BLANK_CYC);
    end else if (s.blank != '0) begin
      next_s.blank = s.blank - 1'b1;
    end

    // Off code must hold before the controller shuts down
    if (!vid_off) begin
      next_s.off_cnt = '0;
      next_s.shutdown = 1'b0;
    end else if (s.off_cnt >= CNT_W'(OFF_CODE_CYCLES - 1)) begin
      next_s.shutdown = 1'b1;
    end else begin
      next_s.off_cnt = s.off_cnt + 1'b1;
    end

    // Turn-on delay starts only once the ramp reaches its target
    if (!enabled) begin
      next_s.ss_reached = 1'b0;
      next_s.mask = CNT_W'(MASK_CYC);
    end else if (!s.ss_reached) begin
      next_s.ss_reached = ss_s;
    end else if (s.mask != '0) begin
      next_s.mask = s.mask - 1'b1;
    end

    // Crowbar: trip is blanked, release needs the low level
    if (!enabled) begin
      next_s.crowbar = 1'b0;
    end else if (trip_s && (s.blank == '0)) begin
      next_s.crowbar = 1'b1;
    end else if (rel_s) begin
      next_s.crowbar = 1'b0;
    end

    // Power good; the window outcome is frozen while blanked
    if (!enabled || vid_off || !s.ss_reached || (s.mask != '0)) begin
      next_s.pgood = 1'b0;
    end else if (s.blank == '0) begin
      next_s.pgood = in_window;
    end

    // Phase disables and PWM
    next_s.pwm_low = !enabled || s.crowbar;
    next_s.always_n = enabled && !s.crowbar;
    next_s.gated_n = enabled && !s.crowbar && psi_n_s;
    if (!enabled) begin
      next_s.phase_en = 4'h0;
    end else if (!psi_n_s) begin
      next_s.phase_en = pgpg_psi_phases(rif.manufacturer_config[PSI_PH_LSB +: 2], nph_s);
    end else begin
      next_s.phase_en = pgpg_all_phases(nph_s);
    end
  end

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  // Reset leaves everything off with PWM forced low and the blanking count at zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s <= '0;
      s.pwm_low <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain power good: drive low unless good
  assign o_power_ok_out_o = 1'b0;
  assign o_power_ok_out_oe_n = s.pgood;
  assign o_gated_phase_disable_n = s.gated_n;
  assign o_always_on_phase_disable_n = s.always_n;
  assign o_pwm_force_low = s.pwm_low;
  assign o_phase_enable = s.phase_en;
  assign o_shutdown = s.shutdown;
  assign o_reg_rdata = rif.rdata;
  // Comparator codes straight from stored limits; crowbar shares the high one
  assign o_high_limit_sel = rif.high_limit[HI_LSB +: 2];
  assign o_low_limit_sel = rif.low_limit[LO_LSB +: 3];

endmodule

`default_nettype wire

// >>> test/pgpg_top_asserts.sv
// Purpose: Port-level checks for the supervisor top
// Assumes: One clock, synchronous reset, pins seen three edges late
// Notes: Blanking checks assume enable stays high across a code change
`timescale 1ns/1ps
`default_nettype none
module pgpg_top_asserts (
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_cmd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  // Pins
  input wire logic [7:0] i_voltage_id_code,
  input wire logic i_enable,
  input wire logic i_undervoltage_lockout_clear,
  input wire logic i_low_power_state_in_n,
  // Outputs
  input wire logic o_power_ok_out_oe_n,
  input wire logic o_gated_phase_disable_n,
  input wire logic o_always_on_phase_disable_n,
  input wire logic o_pwm_force_low,
  input wire logic [1:0] o_high_limit_sel,
  input wire logic o_shutdown
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // Off-code persistence counter
  // ----------------------------------------
  logic off_code; // Pins show an off code
  logic [9:0] off_cnt; // Saturating, so long holds cannot wrap
  assign off_code = (i_voltage_id_code == 8'h00) || (i_voltage_id_code == 8'hFF);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !off_code) begin
      off_cnt <= 10'h000;
    end else if (off_cnt != 10'h3FF) begin
      off_cnt <= off_cnt + 10'h001;
    end
  end
  a_disabled_all_low: assert property (
    (!i_enable || !i_undervoltage_lockout_clear)[*3] |=> !o_power_ok_out_oe_n &&
    !o_gated_phase_disable_n && !o_always_on_phase_disable_n && o_pwm_force_low)
    else $error("outputs not forced while disabled");
  a_start_needs_en: assert property (
    (o_always_on_phase_disable_n || o_power_ok_out_oe_n) |->
    $past(i_enable, 3) && $past(i_undervoltage_lockout_clear, 3))
    else $error("output released without enable");
  a_psi_gates: assert property (
    (!i_low_power_state_in_n)[*3] |=> !o_gated_phase_disable_n)
    else $error("gated disable not low in low power");
  a_always_on_up: assert property (
    !o_pwm_force_low && $past(i_enable, 3) && $past(i_undervoltage_lockout_clear, 3)
    |-> o_always_on_phase_disable_n)
    else $error("always-on disable low while running");
  a_high_limit_wr: assert property (
    i_reg_wr && i_reg_cmd == 8'hE0 |=>
    {6'h00, o_high_limit_sel} == ($past(i_reg_wdata) & 8'h03))
    else $error("high limit select not taken");
  a_rdata_high: assert property (
    !i_reg_wr && i_reg_cmd == 8'hE0 |=> o_reg_rdata[1:0] == o_high_limit_sel)
    else $error("high limit readback differs");
  a_adc_width: assert property (
    i_reg_cmd == 8'hD9 |=> o_reg_rdata[15:10] == 6'h00)
    else $error("enable reading wider than 10 bits");
  a_off_persist: assert property (
    $rose(o_shutdown) |-> off_cnt inside {[10'h1EA:10'h203]})
    else $error("shutdown without 5 us off code");
  a_pgood_blanked: assert property (
    $changed(i_voltage_id_code) && !off_code && i_enable |->
    ##4 $stable(o_power_ok_out_oe_n)[*8])
    else $error("power good moved during blanking");
  cover property ($rose(o_shutdown));
  cover property (i_enable && $rose(o_pwm_force_low));
  cover property (!o_gated_phase_disable_n && o_always_on_phase_disable_n);
endmodule
bind pgpg_top pgpg_top_asserts u_pgpg_top_asserts (
  .i_clk, .i_sys_rst, .i_reg_wr, .i_reg_cmd, .i_reg_wdata, .o_reg_rdata,
  .i_voltage_id_code, .i_enable, .i_undervoltage_lockout_clear, .i_low_power_state_in_n,
  .o_power_ok_out_oe_n, .o_gated_phase_disable_n, .o_always_on_phase_disable_n,
  .o_pwm_force_low, .o_high_limit_sel, .o_shutdown
);
`default_nettype wire

// >>> test/pgpg_stage_model.sv
// Purpose: Output stage behind the crowbar comparators
// Assumes: Output level kept in mV, nominal 1000 mV
// Notes: Discharge of 50 mV a clock is a plain model figure
`timescale 1ns/1ps
`default_nettype none
module pgpg_stage_model (
  // Clock and controls
  input wire logic i_clk,
  input wire logic i_pwm_force_low,
  input wire logic [1:0] i_high_limit_sel,
  input wire logic [15:0] i_over_mv,
  // Comparator results
  output logic o_crowbar_trip,
  output logic o_crowbar_release
);
  int vout_mv = 1000; // Present output level
  // Low side on drains the output, else it follows the overshoot
  always @(posedge i_clk) begin
    if (i_pwm_force_low) begin
      vout_mv <= (vout_mv > 50) ? vout_mv - 50 : 0;
    end else begin
      vout_mv <= 1000 + int'(i_over_mv);
    end
  end
  // Trip point tracks the high-limit code, 50 mV a step
  assign o_crowbar_trip = (vout_mv - 1000) > (300 - 50 * int'(i_high_limit_sel));
  assign o_crowbar_release = vout_mv < 300;
endmodule
`default_nettype wire

// >>> test/pgpg_top_tb.sv
// Purpose: Self-checking bench for the supervisor top
// Assumes: Blanking and turn-on delay shortened to a few cycles
// Notes: Pins need three edges to reach outputs, so checks wait five
`timescale 1ns/1ps
`default_nettype none
module pgpg_top_tb;
  import pgpg_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam int BLANK = 20; // Short blanking
  localparam int MASK = 30; // Short turn-on delay
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic wr = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] code = 8'h40; // Voltage code pins
  logic en = 1'b0;
  logic undervoltage_lockout_ok = 1'b0;
  logic psi_n = 1'b1; // Low-power state request
  logic above = 1'b0; // Window comparator
  logic below = 1'b0; // Window comparator, low side
  logic ss_done = 1'b0; // Ramp reached target
  logic [2:0] nph = 3'h4;
  logic adc_v = 1'b0;
  logic [9:0] adc_d = 10'h000;
  logic [15:0] over_mv = 16'h0000; // Overshoot asked of the stage
  logic trip, rel, pg_o, pg_oe_n, gdis_n, adis_n, pwm_low, shdn;
  logic [15:0] rdata;
  logic [3:0] ph_en;
  logic [1:0] hsel;
  logic [2:0] lsel;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // Block under test, both window comparators driven
  pgpg_top #(.BLANK_CYC(BLANK), .MASK_CYC(MASK)) u_pgpg_top (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(wr), .i_reg_cmd(cmd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_voltage_id_code(code), .i_enable(en),
    .i_undervoltage_lockout_clear(undervoltage_lockout_ok), .i_low_power_state_in_n(psi_n),
    .i_window_above(above), .i_window_below(below), .i_crowbar_trip(trip),
    .i_crowbar_release(rel), .i_soft_start_done(ss_done), .i_normal_phases(nph),
    .i_en_adc_valid(adc_v), .i_en_adc_data(adc_d), .o_power_ok_out_o(pg_o),
    .o_power_ok_out_oe_n(pg_oe_n), .o_gated_phase_disable_n(gdis_n),
    .o_always_on_phase_disable_n(adis_n), .o_pwm_force_low(pwm_low), .o_phase_enable(ph_en),
    .o_high_limit_sel(hsel), .o_low_limit_sel(lsel), .o_shutdown(shdn));
  pgpg_stage_model u_pgpg_stage_model (.i_clk(i_clk), .i_pwm_force_low(pwm_low),
    .i_high_limit_sel(hsel), .i_over_mv(over_mv), .o_crowbar_trip(trip),
    .o_crowbar_release(rel));
  // Hang guard, about twenty times the expected run
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    cmd <= c;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] c, input logic [15:0] exp);
    @(posedge i_clk);
    cmd <= c;
    cyc(2);
    chk(rdata, exp);
  endtask
  // Reset values, every limit code, unmapped place
  task automatic t_regs();
    reg_rd(CMD_HIGH_LIMIT, 16'h0000);
    reg_rd(CMD_LOW_LIMIT, 16'h0000);
    reg_rd(CMD_MANUFACTURER_CONFIG, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      reg_wr(CMD_HIGH_LIMIT, 8'(i % 4));
      reg_wr(CMD_LOW_LIMIT, 8'(i));
      reg_rd(CMD_HIGH_LIMIT, 16'(i % 4));
      chk(16'({hsel, lsel}), 16'(((i % 4) << 3) | i));
    end
    reg_wr(CMD_HIGH_LIMIT, 8'h00);
    reg_wr(8'h10, 8'h5A);
    reg_rd(8'h10, 16'h0000);
    @(posedge i_clk);
    adc_v <= 1'b1;
    adc_d <= 10'h2A5;
    @(posedge i_clk);
    adc_v <= 1'b0;
    reg_rd(CMD_EN_VOLTAGE, 16'h02A5);
  endtask
  // Start-up: power good waits for the ramp and the mask
  task automatic t_start();
    @(posedge i_clk);
    en <= 1'b1;
    undervoltage_lockout_ok <= 1'b1;
    cyc(MASK + 10);
    chk(16'({adis_n, pg_oe_n}), 16'h0002);
    @(posedge i_clk);
    ss_done <= 1'b1;
    cyc(MASK - 5);
    chk(16'(pg_oe_n), 16'h0000);
    cyc(15);
    chk(16'(pg_oe_n), 16'h0001);
  endtask
  // Code change blanks an out-of-window output; a second change restarts it
  task automatic t_voltage_code_transition();
    @(posedge i_clk);
    code <= 8'h41;
    repeat (4) @(posedge i_clk);
    above <= 1'b1;
    cyc(8);
    chk(16'(pg_oe_n), 16'h0001);
    @(posedge i_clk);
    code <= 8'h42;
    cyc(15);
    chk(16'(pg_oe_n), 16'h0001);
    cyc(20);
    chk(16'(pg_oe_n), 16'h0000);
    @(posedge i_clk);
    above <= 1'b0;
    cyc(6);
    chk(16'(pg_oe_n), 16'h0001);
    @(posedge i_clk);
    below <= 1'b1;
    cyc(6);
    chk(16'(pg_oe_n), 16'h0000);
    @(posedge i_clk);
    below <= 1'b0;
    cyc(6);
    chk(16'(pg_oe_n), 16'h0001);
  endtask
  // Low-power phase selection for each code
  task automatic t_psi();
    logic [7:0] one[3] = '{8'h00, 8'h80, 8'hC0};
    reg_wr(CMD_MANUFACTURER_CONFIG, 8'h40);
    @(posedge i_clk);
    psi_n <= 1'b0;
    cyc(5);
    chk(16'({gdis_n, adis_n, ph_en}), 16'h0015);
    @(posedge i_clk);
    nph <= 3'h3;
    cyc(5);
    chk(16'(ph_en), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      reg_wr(CMD_MANUFACTURER_CONFIG, one[i]);
      cyc(3);
      chk(16'(ph_en), 16'h0001);
    end
    @(posedge i_clk);
    psi_n <= 1'b1;
    nph <= 3'h2;
    cyc(5);
    chk(16'({gdis_n, ph_en}), 16'h0013);
    @(posedge i_clk);
    nph <= 3'h4;
    cyc(5);
    chk(16'(ph_en), 16'h000F);
  endtask
  // Crowbar trip and release, trip point following the high limit
  task automatic t_crowbar();
    @(posedge i_clk);
    over_mv <= 16'h0190;
    cyc(6);
    chk(16'(pwm_low), 16'h0001);
    @(posedge i_clk);
    over_mv <= 16'h00C8;
    cyc(60);
    chk(16'(pwm_low), 16'h0000);
    reg_wr(CMD_HIGH_LIMIT, 8'h03);
    cyc(6);
    chk(16'(pwm_low), 16'h0001);
    @(posedge i_clk);
    over_mv <= 16'h0000;
    cyc(60);
    chk(16'(pwm_low), 16'h0000);
    reg_wr(CMD_HIGH_LIMIT, 8'h00);
  endtask
  // Enable low, then lockout, each drop power good and both disables and force PWM low
  task automatic t_disable();
    @(posedge i_clk);
    en <= 1'b0;
    cyc(5);
    chk(16'({pg_oe_n, gdis_n, adis_n, pwm_low}), 16'h0001);
    @(posedge i_clk);
    en <= 1'b1;
    undervoltage_lockout_ok <= 1'b0;
    cyc(5);
    chk(16'({pg_oe_n, gdis_n, adis_n, pwm_low}), 16'h0001);
    @(posedge i_clk);
    undervoltage_lockout_ok <= 1'b1;
    cyc(MASK + 20);
    chk(16'({adis_n, pg_oe_n}), 16'h0003);
  endtask
  // Off code drops power good at once, shutdown only after persisting
  task automatic t_off();
    @(posedge i_clk);
    code <= VID_OFF_LO;
    cyc(5);
    chk(16'({pg_o, pg_oe_n}), 16'h0000);
    cyc(OFF_CODE_CYCLES - 20);
    chk(16'(shdn), 16'h0000);
    cyc(30);
    chk(16'(shdn), 16'h0001);
  endtask
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_start();
    t_voltage_code_transition();
    t_psi();
    t_crowbar();
    t_disable();
    t_off();
    finish_test();
  end
endmodule
`default_nettype wire
